// ### lscl_map.svh
/*
  Constants for the low-side configuration and loopback register bank:
  management address, register offsets, field positions, reset values,
  the read-as-zero bit mask, lane count and synchroniser depth.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef LSCL_MAP_SVH
`define LSCL_MAP_SVH

`define LSCL_DEVAD            5'h1E
`define LSCL_OFS_LOOPBACK     16'h000B
`define LSCL_OFS_CONFIG       16'h000C

`define LSCL_LOOPBACK_RESET   16'h0D10
`define LSCL_CONFIG_RESET     16'h0330

`define LSCL_BIT_DEEP_LOOP    3
`define LSCL_BIT_NEAR_LOOP    0

`define LSCL_BIT_SEL_HI       13
`define LSCL_BIT_SEL_LO       12
`define LSCL_BIT_LOS_IGNORE   5
`define LSCL_BIT_LOCK_IGNORE  4
`define LSCL_BIT_REALIGN      2

`define LSCL_CONFIG_RAZ_MASK  16'h0C08
`define LSCL_LANES            4
`define LSCL_SYNC_STAGES      2

`endif

// ### lscl_pkg.sv
/*
  Types for the low-side configuration and loopback register bank.
  Assumes lscl_map.svh is on the include path.
*/
`include "lscl_map.svh"

package lscl_pkg;

  typedef logic [15:0] lscl_word_t;
  typedef logic [`LSCL_LANES-1:0] lscl_lanes_t;

  // one management access, as handed over by the frame decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] devad;
    lscl_word_t addr;
    lscl_word_t wdata;
  } lscl_mgmt_req_s;

  // settings that steer the link status logic
  typedef struct packed {
    logic [1:0] lane_sel;
    logic       los_ignore;
    logic       lock_ignore;
  } lscl_mon_cfg_s;

  // raw per-lane state from the low-side serdes
  typedef struct packed {
    lscl_lanes_t los;
    lscl_lanes_t aligned;
    logic        pll_lock;
  } lscl_serdes_s;

  typedef enum logic [1:0] {
    LSCL_RD_NONE,
    LSCL_RD_LOOPBACK,
    LSCL_RD_CONFIG
  } lscl_rsel_e;

endpackage : lscl_pkg

// ### lscl_link_combine.sv
/*
  Link status combiner: merges the unmasked low-side sources into one
  link status level and picks the lane whose state feeds the status word.
  Assumes all inputs are already synchronous to mclk.
*/
`timescale 1ns/100ps
`default_nettype none

module lscl_link_combine
  import lscl_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire lscl_mon_cfg_s cfg,
  input  wire lscl_serdes_s  serdes,
  input  wire lscl_lanes_t   lane_enable,
  output logic               link_status,
  output logic               lane_status_bit
);

  logic los_clean;
  logic lock_ok;
  logic link_d;
  logic lane_d;
  logic link_q;
  logic lane_q;

  // only enabled lanes may pull the link down on signal loss
  assign los_clean = ~|(serdes.los & lane_enable);
  assign lock_ok   = serdes.pll_lock;
  assign link_d    = (cfg.los_ignore  | los_clean)
                   & (cfg.lock_ignore | lock_ok);
  assign lane_d    = serdes.aligned[cfg.lane_sel];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link_q <= 1'b0;
      lane_q <= 1'b0;
    end else begin
      link_q <= link_d;
      lane_q <= lane_d;
    end
  end

  assign link_status     = link_q;
  assign lane_status_bit = lane_q;

endmodule // lscl_link_combine

`default_nettype wire

// ### lscl_regs.sv
/*
  Low-side configuration and loopback register bank: the loopback and
  test-pattern control word and the low-side configuration word, reached
  through the management register port, with the loopback enables, the
  realign force and the link status they steer.
  Assumes a management frame decoder on mclk that presents one access per
  request pulse, and serdes status pins asynchronous to mclk.

  // Summary of operation
  // - loopback word bit 3 set enables deep remote loopback, clear is normal.
  // - loopback word bit 0 set enables shallow local loopback, clear is normal.
  // - both loopback enables are zero after reset.
  // - config bits 13:12 pick lane 0 to 3 for status word bit 14, reset 00.
  // - config bit 5 clear lets enabled-lane signal loss feed link status, reset 1.
  // - config bit 4 clear lets pll lock feed link status, reset 1.
  // - config bit 2 set forces the link monitor to realign lanes, reset 0.
  // - the config word sits at register 0x000C of device 0x1E, reset 0x0330.
  // - config bits 11:10 and 3 always read zero whatever was written.
  // - config bits 9:8 reset to 11 and software keeps reserved fields intact.
*/
`timescale 1ns/100ps
`default_nettype none

`include "lscl_map.svh"

module lscl_regs
  import lscl_pkg::*;
#(
  parameter logic [4:0] DEVAD       = `LSCL_DEVAD,
  parameter int         SYNC_STAGES = `LSCL_SYNC_STAGES
)
(
  input  wire logic           mclk,
  input  wire logic           rst_n,
  input  wire lscl_mgmt_req_s mgmt_req,
  output logic                mgmt_ack,
  output logic                mgmt_rvalid,
  output lscl_word_t          mgmt_rdata,
  input  wire lscl_serdes_s   serdes_pins,
  input  wire lscl_lanes_t    lane_enable,
  output logic                deep_far_loop_en,
  output logic                near_side_loop_en,
  output logic                monitor_realign_force,
  output logic                link_status,
  output logic                lane_status_bit,
  output logic [1:0]          lane_status_select
);

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("lscl_regs: SYNC_STAGES must be at least 2");
  end
  if (DEVAD > 5'h1F) begin : g_bad_devad
    $error("lscl_regs: DEVAD out of range");
  end

  localparam int SW = $bits(lscl_serdes_s);

  // writable bits of the config word; read-as-zero bits never store
  function automatic lscl_word_t cfg_store(input lscl_word_t wd);
    cfg_store = wd & ~`LSCL_CONFIG_RAZ_MASK;
  endfunction

  // decode one register offset within this device
  function automatic logic ofs_hit(input lscl_mgmt_req_s r,
                                   input lscl_word_t ofs);
    ofs_hit = (r.devad == DEVAD) && (r.addr == ofs);
  endfunction

  lscl_word_t     loop_q;
  lscl_word_t     loop_d;
  lscl_word_t     cfg_q;
  lscl_word_t     cfg_d;
  lscl_word_t     rdata_q;
  lscl_word_t     rdata_d;
  logic           rvalid_q;
  lscl_rsel_e     rsel;
  logic           dev_hit;
  logic           hit_loop;
  logic           hit_cfg;
  logic           wr_loop;
  logic           wr_cfg;
  logic           rd_any;
  lscl_mon_cfg_s  mon_cfg;
  lscl_serdes_s   serdes_sync;
  logic [SW-1:0]  sync_q [SYNC_STAGES];

  // request decode
  assign dev_hit  = (mgmt_req.devad == DEVAD);
  assign hit_loop = ofs_hit(mgmt_req, `LSCL_OFS_LOOPBACK);
  assign hit_cfg  = ofs_hit(mgmt_req, `LSCL_OFS_CONFIG);
  assign wr_loop  = mgmt_req.wr & hit_loop;
  assign wr_cfg   = mgmt_req.wr & hit_cfg;
  assign rd_any   = mgmt_req.rd & dev_hit;

  // a request for another device address is left to its own bank
  assign mgmt_ack = (mgmt_req.wr | mgmt_req.rd) & dev_hit;

  assign rsel = !rd_any  ? LSCL_RD_NONE     :
                hit_loop ? LSCL_RD_LOOPBACK :
                hit_cfg  ? LSCL_RD_CONFIG   : LSCL_RD_NONE;

  // whole word stored; test-pattern fields are held for their consumers
  assign loop_d = wr_loop ? mgmt_req.wdata : loop_q;
  // reserved 9:8, 15:14, 7:6, 1:0 keep what software writes back
  assign cfg_d  = wr_cfg ? cfg_store(mgmt_req.wdata) : cfg_q;

  always_comb begin
    unique case (rsel)
      LSCL_RD_LOOPBACK: rdata_d = loop_q;
      LSCL_RD_CONFIG:   rdata_d = cfg_q & ~`LSCL_CONFIG_RAZ_MASK;
      LSCL_RD_NONE:     rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      loop_q <= `LSCL_LOOPBACK_RESET;
      cfg_q  <= `LSCL_CONFIG_RESET;
    end else begin
      loop_q <= loop_d;
      cfg_q  <= cfg_d;
    end
  end

  // read answer one edge after the request; unmapped offsets read zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rd_any ? rdata_d : rdata_q;
      rvalid_q <= rd_any;
    end
  end

  assign mgmt_rdata  = rdata_q;
  assign mgmt_rvalid = rvalid_q;

  // serdes status is analog-side and free running, so it is synchronised
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_q[i] <= '0;
      end
    end else begin
      sync_q[0] <= serdes_pins;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_q[i] <= sync_q[i-1];
      end
    end
  end

  assign serdes_sync = sync_q[SYNC_STAGES-1];

  // fields that steer the block
  assign deep_far_loop_en      = loop_q[`LSCL_BIT_DEEP_LOOP];
  assign near_side_loop_en     = loop_q[`LSCL_BIT_NEAR_LOOP];
  assign monitor_realign_force = cfg_q[`LSCL_BIT_REALIGN];
  assign lane_status_select    = cfg_q[`LSCL_BIT_SEL_HI:`LSCL_BIT_SEL_LO];

  assign mon_cfg.lane_sel    = cfg_q[`LSCL_BIT_SEL_HI:`LSCL_BIT_SEL_LO];
  assign mon_cfg.los_ignore  = cfg_q[`LSCL_BIT_LOS_IGNORE];
  assign mon_cfg.lock_ignore = cfg_q[`LSCL_BIT_LOCK_IGNORE];

  // realign is a level; the monitor restarts alignment while it is held
  lscl_link_combine u_combine (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .cfg             (mon_cfg),
    .serdes          (serdes_sync),
    .lane_enable     (lane_enable),
    .link_status     (link_status),
    .lane_status_bit (lane_status_bit)
  );

endmodule // lscl_regs

`default_nettype wire

// ### lscl_regs_asserts.sv
/* port checker for lscl_regs.
   assumes the bind below reaches every lscl_regs instance. */
`timescale 1ns/100ps
`default_nettype none
module lscl_regs_chk
  import lscl_pkg::*;
(
  input wire logic           mclk,
  input wire logic           rst_n,
  input wire lscl_mgmt_req_s mgmt_req,
  input wire logic           mgmt_ack,
  input wire logic           mgmt_rvalid,
  input wire lscl_word_t     mgmt_rdata,
  input wire logic           deep_far_loop_en,
  input wire logic           near_side_loop_en,
  input wire logic           monitor_realign_force,
  input wire logic [1:0]     lane_status_select
);
  wire logic       hit = mgmt_req.devad == 5'h1E;
  wire logic       rdh = mgmt_req.rd && hit;
  wire logic       wlb = mgmt_req.wr && hit && mgmt_req.addr == 16'h000B;
  wire logic       wcf = mgmt_req.wr && hit && mgmt_req.addr == 16'h000C;
  wire logic       rcf = rdh && mgmt_req.addr == 16'h000C;
  wire lscl_word_t wd  = mgmt_req.wdata;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ack_decode_a: assert property (
    mgmt_ack == ((mgmt_req.wr | mgmt_req.rd) && hit)) else $error("bad ack");
  read_valid_a: assert property (
    mgmt_rvalid == $past(rdh)) else $error("bad rvalid");
  raz_read_a: assert property (
    rcf |=> (mgmt_rdata & 16'h0C08) == 16'h0000) else $error("raz bits set");
  deep_loop_a: assert property (
    wlb |=> deep_far_loop_en == $past(wd[3])) else $error("deep loop");
  near_loop_a: assert property (
    wlb |=> near_side_loop_en == $past(wd[0])) else $error("near loop");
  lane_sel_a: assert property (
    wcf |=> lane_status_select == $past(wd[13:12])) else $error("lane sel");
  realign_set_a: assert property (
    wcf |=> monitor_realign_force == $past(wd[2])) else $error("realign");
  reset_clear_a: assert property (
    $rose(rst_n) |-> lane_status_select == 2'b00 && !(deep_far_loop_en |
    near_side_loop_en | monitor_realign_force)) else $error("reset value");
endmodule // lscl_regs_chk
bind lscl_regs lscl_regs_chk chk_u (.mclk, .rst_n, .mgmt_req, .mgmt_ack,
  .mgmt_rvalid, .mgmt_rdata, .deep_far_loop_en, .near_side_loop_en,
  .monitor_realign_force, .lane_status_select);
`default_nettype wire

// ### lscl_host_model.sv
/* management host model: one access per call, driven on falling edges.
   assumes read data arrives with rvalid one edge after the request. */
`timescale 1ns/100ps
`default_nettype none
module lscl_host_model
  import lscl_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           mgmt_ack,
  input  wire logic           mgmt_rvalid,
  input  wire lscl_word_t     mgmt_rdata,
  output var  lscl_mgmt_req_s req
);
  logic ack_seen = 1'b0;
  initial req = '0;
  task automatic acc(input logic w, input logic [4:0] dv,
    input lscl_word_t a, input lscl_word_t d, input logic raw,
    output logic v, output lscl_word_t q);
    lscl_word_t dd;
    dd = d;
    // raw lets a test probe reserved bits software normally leaves alone
    if (!raw && a == 16'h000C) {dd[15:14], dd[9:8]} = 4'h3;
    @(negedge mclk);
    req = '{w, !w, dv, a, dd};
    #1 ack_seen = mgmt_ack;
    @(negedge mclk);
    v = mgmt_rvalid;
    q = mgmt_rdata;
    // released lines show the inverse rather than a stale copy
    req = '{1'b0, 1'b0, ~dv, ~a, ~dd};
  endtask
endmodule // lscl_host_model
`default_nettype wire

// ### lscl_regs_bench.sv
/* self-checking bench for lscl_regs against an integer model.
   assumes the design, checker and host model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module lscl_regs_bench
  import lscl_pkg::*;
;
  logic           mclk = 1'b0;
  logic           rst_n = 1'b0;
  lscl_mgmt_req_s req;
  logic           ack, rvalid, v, dfl, nsl, rfc, link, lsb;
  lscl_word_t     rdata, q, d, a;
  logic [1:0]     sel;
  lscl_serdes_s   sp = '0;
  lscl_lanes_t    le = '0;
  int             seed = 32'h18A8, num_errors = 0, cmp_count = 0;
  int             i, cfg_m, lb_m;
  always #25 mclk = ~mclk;
  lscl_regs dut_u (.mclk, .rst_n, .mgmt_req(req), .mgmt_ack(ack),
    .mgmt_rvalid(rvalid), .mgmt_rdata(rdata), .serdes_pins(sp),
    .lane_enable(le), .deep_far_loop_en(dfl), .near_side_loop_en(nsl),
    .monitor_realign_force(rfc), .link_status(link),
    .lane_status_bit(lsb), .lane_status_select(sel));
  lscl_host_model host_u (.mclk, .mgmt_ack(ack), .mgmt_rvalid(rvalid),
    .mgmt_rdata(rdata), .req);
  task automatic chk(input lscl_word_t g, input lscl_word_t e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input lscl_word_t ra);
    lscl_word_t e;
    e = ra == 16'h000C ? 16'(cfg_m) : ra == 16'h000B ? 16'(lb_m) : 16'h0;
    host_u.acc(1'b0, 5'h1E, ra, 16'h0000, 1'b0, v, q);
    chk({14'h0, v, host_u.ack_seen}, 16'h0003);
    chk(q, e);
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    cfg_m = 16'h0330;
    lb_m = 16'h0D10;
    rd_chk(16'h000C);
    rd_chk(16'h000B);
    rd_chk(16'h0007);
    chk({11'h0, sel, rfc, dfl, nsl}, 16'h0000);
    for (i = 0; i < 16; i++) begin
      d = 16'($random(seed));
      a = i[0] ? 16'h000C : 16'h000B;
      // walk every mask pair and lane code on the config writes
      if (i[0]) d[5:4] = i[2:1];
      if (i[0]) d[13:12] = i[3:2];
      host_u.acc(1'b1, 5'h1E, a, d, i == 1, v, q);
      chk({15'h0, host_u.ack_seen}, 16'h0001);
      if (i[0] && i != 1) {d[15:14], d[9:8]} = 4'h3;
      if (i[0]) cfg_m = d & 16'hF3F7;
      else lb_m = d;
      chk({11'h0, sel, rfc, dfl, nsl}, {11'h0, 2'(cfg_m >> 12),
        cfg_m[2], lb_m[3], lb_m[0]});
      rd_chk(a);
      {sp, le} = 13'($random(seed));
      repeat (4) @(negedge mclk);
      chk({14'h0, link, lsb}, {14'h0,
        (cfg_m[5] | ~|(sp.los & le)) & (cfg_m[4] | sp.pll_lock),
        sp.aligned[2'(cfg_m >> 12)]});
    end
    host_u.acc(1'b0, 5'h1D, 16'h000C, 16'h0000, 1'b0, v, q);
    chk({14'h0, v, host_u.ack_seen}, 16'h0000);
    // refused and unmapped writes must leave both words untouched
    host_u.acc(1'b1, 5'h1D, 16'h000C, 16'hFFFF, 1'b1, v, q);
    chk({15'h0, host_u.ack_seen}, 16'h0000);
    host_u.acc(1'b1, 5'h1E, 16'h0007, 16'hFFFF, 1'b1, v, q);
    rd_chk(16'h000C);
    rd_chk(16'h000B);
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    cfg_m = 16'h0330;
    lb_m = 16'h0D10;
    rd_chk(16'h000C);
    chk({11'h0, sel, rfc, dfl, nsl}, 16'h0000);
    report_and_stop;
  end
endmodule // lscl_regs_bench
`default_nettype wire
